// ### include/pmt_regs.vh
// constants for the pseudowire payload-size tracker
// assumes a 10 MHz system clock and icmp messages delivered without their outer ip header
`ifndef PMT_REGS_VH
`define PMT_REGS_VH
`define PMT_FRAME_MAX   16'h07D0
`define PMT_ETH_OVH     16'h0012
`define PMT_IP_HDR      16'h0014
`define PMT_MPT_HDR     16'h0004
`define PMT_SESS_FIELD  16'h0004
`define PMT_PSP_BASE    16'h0004
`define PMT_ICMP_TYPE   8'h03
`define PMT_ICMP_CODE   8'h04
`define PMT_OFS_TYPE    6'h00
`define PMT_OFS_CODE    6'h01
`define PMT_OFS_MTU_HI  6'h06
`define PMT_OFS_MTU_LO  6'h07
`define PMT_OFS_SRC     6'h14
`define PMT_OFS_DST     6'h18
`define PMT_MSG_MIN     6'h24
`define PMT_CLK_KHZ     10000
`define PMT_RESTORE_MS  10000
`endif

// ### rtl/pmt_tracker.v
// payload-size tracker for the downstream pseudowire, with its icmp input fifo
// assumes icmp bytes arrive on a valid/ready stream and sessions are set up by local control
`timescale 1ns/1ps
`include "pmt_regs.vh"

// ----------------------------------------
// input fifo
// ----------------------------------------
module pmt_fifo #(
   parameter W  = 9,
   parameter D  = 16,
   parameter AW = 4
) (
   // clock and reset
   input  wire          clock,
   input  wire          rst_n,
   // fill side
   input  wire          in_valid,
   output wire          in_ready,
   input  wire [W-1:0]  in_data,
   // drain side
   output wire          out_valid,
   input  wire          out_ready,
   output wire [W-1:0]  out_data
);
   reg [W-1:0]  mem_r [0:D-1];
   reg [AW-1:0] wp_r;
   reg [AW-1:0] rp_r;
   reg [AW:0]   cnt_r;
   wire         push;
   wire         pop;
   integer      i;

   assign in_ready  = (cnt_r < D);
   assign out_valid = (cnt_r != {(AW+1){1'b0}});
   assign out_data  = mem_r[rp_r];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         wp_r  <= {AW{1'b0}};
         rp_r  <= {AW{1'b0}};
         cnt_r <= {(AW+1){1'b0}};
         for (i = 0; i < D; i = i + 1) begin
            mem_r[i] <= {W{1'b0}};
         end
      end else begin
         if (push) begin
            mem_r[wp_r] <= in_data;
            wp_r        <= wp_r + 1'b1;
         end
         if (pop) begin
            rp_r <= rp_r + 1'b1;
         end
         if (push && !pop) begin
            cnt_r <= cnt_r + 1'b1;
         end else if (pop && !push) begin
            cnt_r <= cnt_r - 1'b1;
         end
      end
   end
endmodule

// ----------------------------------------
// tracker top
// ----------------------------------------
module pmt_tracker #(
   parameter RESTORE_CYCLES = `PMT_RESTORE_MS * `PMT_CLK_KHZ
) (
   // clock and reset
   input  wire         clock,
   input  wire         rst_n,
   // received icmp message bytes
   input  wire         icmp_valid,
   output wire         icmp_ready,
   input  wire [7:0]   icmp_data,
   input  wire         icmp_last,
   // control connection table
   input  wire         cc_we,
   input  wire [1:0]   cc_idx,
   input  wire         cc_active,
   input  wire [31:0]  cc_src_addr,
   input  wire [31:0]  cc_dst_addr,
   // session table
   input  wire         sess_we,
   input  wire [2:0]   sess_idx,
   input  wire         sess_active,
   input  wire [1:0]   sess_cc,
   input  wire [15:0]  sess_neg_max,
   input  wire         sess_psp_mode,
   input  wire [5:0]   sess_max_segs,
   // policy
   input  wire         static_en,
   input  wire [15:0]  static_limit,
   input  wire         restore_en,
   // session readout
   input  wire [2:0]   rd_idx,
   output reg  [15:0]  rd_limit_r,
   output reg  [15:0]  rd_payload_r,
   // frame length check
   input  wire [15:0]  frame_len,
   output reg          frame_ok_r,
   // transmit header flag
   output reg          tx_df_flag_r,
   // message outcome pulses
   output reg          msg_applied_r,
   output reg          msg_dropped_r
);
   localparam ST_RECV  = 1'b0;
   localparam ST_APPLY = 1'b1;
   localparam NCC      = 4;
   localparam NSESS    = 8;

   function [15:0] min16;
      input [15:0] a;
      input [15:0] b;
      begin
         min16 = (a < b) ? a : b;
      end
   endfunction

   // ----------------------------------------
   // storage
   // ----------------------------------------
   reg         cc_act_r  [0:NCC-1];
   reg [31:0]  cc_src_r  [0:NCC-1];
   reg [31:0]  cc_dst_r  [0:NCC-1];
   reg         s_act_r   [0:NSESS-1];
   reg [1:0]   s_cc_r    [0:NSESS-1];
   reg [15:0]  s_neg_r   [0:NSESS-1];
   reg [15:0]  s_cur_r   [0:NSESS-1];
   reg         s_psp_r   [0:NSESS-1];
   reg [5:0]   s_segs_r  [0:NSESS-1];

   reg         state_r;
   reg [5:0]   cnt_r;
   reg [7:0]   type_r;
   reg [7:0]   code_r;
   reg [15:0]  mtu_r;
   reg [31:0]  src_r;
   reg [31:0]  dst_r;
   reg         good_r;
   reg [31:0]  tmr_r;
   reg         restore_r;
   wire        f_valid;
   wire [8:0]  f_data;
   wire        f_ready;
   wire        pop;
   wire [5:0]  cnt_nxt;
   wire        good_nxt;
   wire        apply_go;
   wire [15:0] ip_limit;
   reg         hit;
   reg [1:0]   hit_idx;
   integer     i, ci, si;
   pmt_fifo #(
      .W  (9),
      .D  (16),
      .AW (4)
   ) u_fifo (
      .clock     (clock),
      .rst_n     (rst_n),
      .in_valid  (icmp_valid),
      .in_ready  (icmp_ready),
      .in_data   ({icmp_last, icmp_data}),
      .out_valid (f_valid),
      .out_ready (f_ready),
      .out_data  (f_data)
   );

   // ----------------------------------------
   // message parser
   // ----------------------------------------
   // draining stops for the apply cycle, so a burst backs up into the fifo
   assign f_ready  = (state_r == ST_RECV);
   assign pop      = f_valid & f_ready;
   assign cnt_nxt  = (cnt_r == 6'h3F) ? cnt_r : cnt_r + 6'h01;
   assign good_nxt = (type_r == `PMT_ICMP_TYPE) && (code_r == `PMT_ICMP_CODE)
                     && (cnt_nxt >= `PMT_MSG_MIN)
                     && (mtu_r != 16'h0000);
   assign apply_go = (state_r == ST_APPLY) && good_r;

   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= ST_RECV;
         cnt_r   <= 6'h00;
         type_r  <= 8'h00;
         code_r  <= 8'h00;
         mtu_r   <= 16'h0000;
         src_r   <= 32'h00000000;
         dst_r   <= 32'h00000000;
         good_r  <= 1'b0;
      end else begin
         case (state_r)
            ST_RECV: begin
               if (pop) begin
                  cnt_r <= cnt_nxt;
                  if (cnt_r == `PMT_OFS_TYPE) type_r <= f_data[7:0];
                  if (cnt_r == `PMT_OFS_CODE) code_r <= f_data[7:0];
                  if (cnt_r == `PMT_OFS_MTU_HI) mtu_r[15:8] <= f_data[7:0];
                  if (cnt_r == `PMT_OFS_MTU_LO) mtu_r[7:0] <= f_data[7:0];
                  // embedded source and destination addresses
                  if (cnt_r >= `PMT_OFS_SRC && cnt_r < `PMT_OFS_DST) begin
                     src_r <= {src_r[23:0], f_data[7:0]};
                  end
                  if (cnt_r >= `PMT_OFS_DST && cnt_r < `PMT_OFS_DST + 6'h04) begin
                     dst_r <= {dst_r[23:0], f_data[7:0]};
                  end
                  if (f_data[8]) begin
                     good_r  <= good_nxt;
                     state_r <= ST_APPLY;
                  end
               end
            end
            ST_APPLY: begin
               cnt_r   <= 6'h00;
               state_r <= ST_RECV;
            end
            default: begin
               state_r <= ST_RECV;
            end
         endcase
      end
   end

   // ----------------------------------------
   // connection match
   // ----------------------------------------
   always @* begin
      hit     = 1'b0;
      hit_idx = 2'b00;
      for (i = 0; i < NCC; i = i + 1) begin
         if (!hit && cc_act_r[i] && cc_src_r[i] == src_r && cc_dst_r[i] == dst_r) begin
            hit     = 1'b1;
            hit_idx = i[1:0];
         end
      end
   end

   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         for (ci = 0; ci < NCC; ci = ci + 1) begin
            cc_act_r[ci] <= 1'b0;
            cc_src_r[ci] <= 32'h00000000;
            cc_dst_r[ci] <= 32'h00000000;
         end
      end else if (cc_we) begin
         cc_act_r[cc_idx] <= cc_active;
         cc_src_r[cc_idx] <= cc_src_addr;
         cc_dst_r[cc_idx] <= cc_dst_addr;
      end
   end

   // ----------------------------------------
   // restore timer
   // ----------------------------------------
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         tmr_r     <= 32'h00000000;
         restore_r <= 1'b0;
      end else if (restore_en && tmr_r >= RESTORE_CYCLES - 1) begin
         tmr_r     <= 32'h00000000;
         restore_r <= 1'b1;
      end else begin
         tmr_r     <= restore_en ? tmr_r + 32'h00000001 : 32'h00000000;
         restore_r <= 1'b0;
      end
   end

   // ----------------------------------------
   // session limits
   // ----------------------------------------
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         for (si = 0; si < NSESS; si = si + 1) begin
            s_act_r[si]  <= 1'b0;
            s_cc_r[si]   <= 2'b00;
            s_neg_r[si]  <= 16'h0000;
            s_cur_r[si]  <= 16'h0000;
            s_psp_r[si]  <= 1'b0;
            s_segs_r[si] <= 6'h00;
         end
      end else begin
         for (si = 0; si < NSESS; si = si + 1) begin
            if (sess_we && sess_idx == si[2:0]) begin
               s_act_r[si]  <= sess_active;
               s_cc_r[si]   <= sess_cc;
               s_neg_r[si]  <= sess_neg_max;
               s_cur_r[si]  <= sess_neg_max;
               s_psp_r[si]  <= sess_psp_mode;
               s_segs_r[si] <= sess_max_segs;
            end else if (restore_r) begin
               s_cur_r[si] <= s_neg_r[si];
            end else if (apply_go && hit && s_act_r[si] && s_cc_r[si] == hit_idx) begin
               // lower only, never above the negotiated maximum
               s_cur_r[si] <= min16(min16(s_cur_r[si], mtu_r), s_neg_r[si]);
            end
         end
      end
   end

   // ----------------------------------------
   // sizing and readout
   // ----------------------------------------
   // layer 3 room left by the expanded ethernet frame
   assign ip_limit = `PMT_FRAME_MAX - `PMT_ETH_OVH;
   reg [15:0] eff, ovh, room;
   always @* begin
      eff = static_en ? min16(static_limit, s_neg_r[rd_idx])
                      : min16(s_cur_r[rd_idx], ip_limit);
      if (s_psp_r[rd_idx]) begin
         ovh = `PMT_SESS_FIELD + `PMT_PSP_BASE
               + {9'h000, s_segs_r[rd_idx], 1'b0};
      end else begin
         ovh = `PMT_SESS_FIELD + `PMT_MPT_HDR;
      end
      room = `PMT_IP_HDR + ovh;
   end

   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rd_limit_r    <= 16'h0000;
         rd_payload_r  <= 16'h0000;
         frame_ok_r    <= 1'b0;
         tx_df_flag_r  <= 1'b0;
         msg_applied_r <= 1'b0;
         msg_dropped_r <= 1'b0;
      end else begin
         rd_limit_r    <= eff;
         rd_payload_r  <= (eff > room) ? eff - room : 16'h0000;
         frame_ok_r    <= (frame_len != 16'h0000) && (frame_len <= `PMT_FRAME_MAX);
         tx_df_flag_r  <= 1'b1;
         msg_applied_r <= apply_go && hit;
         msg_dropped_r <= (state_r == ST_APPLY) && !(good_r && hit);
      end
   end
endmodule

// ### bench/pmt_tracker_asserts.sv
// checker for the payload-size tracker top
// assumes one clock domain and the tracker's own port names
`timescale 1ns/1ps
module pmt_chk (
   // clock and reset
   input wire        clock,
   input wire        rst_n,
   // watched ports
   input wire        icmp_valid,
   input wire        icmp_ready,
   input wire        icmp_last,
   input wire        sess_we,
   input wire        static_en,
   input wire        restore_en,
   input wire [2:0]  rd_idx,
   input wire [15:0] rd_limit_r,
   input wire [15:0] rd_payload_r,
   input wire [15:0] frame_len,
   input wire        frame_ok_r,
   input wire        tx_df_flag_r,
   input wire        msg_applied_r,
   input wire        msg_dropped_r
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   a_df_always_set: assert property ($past(rst_n) |-> tx_df_flag_r)
      else $error("df flag low");
   a_frame_len_ok: assert property ($past(rst_n) |-> frame_ok_r ==
      ($past(frame_len) != 16'h0000 && $past(frame_len) <= 16'h07D0))
      else $error("frame length verdict wrong");
   a_outcome_single: assert property (!(msg_applied_r && msg_dropped_r))
      else $error("applied and dropped together");
   a_applied_pulse: assert property (msg_applied_r |=> !msg_applied_r)
      else $error("applied pulse too long");
   a_limit_cap: assert property (!static_en && !$past(static_en) |-> rd_limit_r <= 16'h07BE)
      else $error("limit above frame bound");
   a_payload_room: assert property (rd_payload_r == 16'h0000 ||
      rd_payload_r + 16'h001C <= rd_limit_r)
      else $error("payload leaves no header room");
   a_never_raise: assert property (!sess_we && !$past(sess_we) && !restore_en &&
      !$past(restore_en, 2) && !static_en && !$past(static_en) && $stable(rd_idx)
      |=> rd_limit_r <= $past(rd_limit_r))
      else $error("limit raised");
   a_msg_answered: assert property (icmp_valid && icmp_ready && icmp_last |->
      ##[1:60] (msg_applied_r || msg_dropped_r))
      else $error("message unanswered");
   c_applied: cover property (msg_applied_r);
   c_dropped: cover property (msg_dropped_r);
   c_full: cover property (!icmp_ready);
endmodule
bind pmt_tracker pmt_chk i_chk (.clock(clock), .rst_n(rst_n), .icmp_valid(icmp_valid),
   .icmp_ready(icmp_ready), .icmp_last(icmp_last), .sess_we(sess_we),
   .static_en(static_en), .restore_en(restore_en), .rd_idx(rd_idx),
   .rd_limit_r(rd_limit_r), .rd_payload_r(rd_payload_r), .frame_len(frame_len),
   .frame_ok_r(frame_ok_r), .tx_df_flag_r(tx_df_flag_r),
   .msg_applied_r(msg_applied_r), .msg_dropped_r(msg_dropped_r));

// ### bench/pmt_peer.sv
// network-side model sending icmp messages as a byte stream
// assumes the tracker's valid/ready input on the same clock
`timescale 1ns/1ps
module pmt_peer (
   // clock and reset
   input  wire        clock,
   input  wire        rst_n,
   // message request
   input  wire        go,
   input  wire        slow,
   input  wire [7:0]  m_type,
   input  wire [7:0]  m_code,
   input  wire [15:0] m_mtu,
   input  wire [31:0] m_src,
   input  wire [31:0] m_dst,
   input  wire [5:0]  m_len,
   output reg         busy,
   // byte stream
   output reg         icmp_valid,
   input  wire        icmp_ready,
   output reg  [7:0]  icmp_data,
   output reg         icmp_last
);
   reg  [5:0] n;
   reg        st;
   wire       tk = icmp_valid & icmp_ready;
   wire [5:0] i  = go ? 6'h00 : (tk ? n + 6'h01 : n);
   function [7:0] bt(input [5:0] x);
      case (x)
         6'h00: bt = m_type;
         6'h01: bt = m_code;
         6'h06: bt = m_mtu[15:8];
         6'h07: bt = m_mtu[7:0];
         6'h14, 6'h15, 6'h16, 6'h17: bt = 8'(m_src >> (8'd24 - {x[1:0], 3'b000}));
         6'h18, 6'h19, 6'h1A, 6'h1B: bt = 8'(m_dst >> (8'd24 - {x[1:0], 3'b000}));
         default: bt = {2'b00, x} ^ 8'hA5;
      endcase
   endfunction
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         {busy, icmp_valid, icmp_last, icmp_data, n} <= '0;
      end else if (icmp_valid && !icmp_ready) begin
         n <= n;
      end else if (go || (busy && !(tk && icmp_last))) begin
         st = slow && $urandom_range(1, 0) == 1;
         busy       <= 1'b1;
         n          <= i;
         icmp_valid <= !st;
         icmp_data  <= st ? ~icmp_data : bt(i);
         icmp_last  <= !st && i == m_len - 6'h01;
      end else begin
         busy       <= 1'b0;
         icmp_valid <= 1'b0;
         icmp_data  <= ~icmp_data;
         icmp_last  <= 1'b0;
      end
   end
endmodule

// ### bench/tb_top.sv
// self-checking bench for the payload-size tracker
// assumes the peer model drives the icmp stream
`timescale 1ns/1ps
module tb_top;
   reg         clock, rst_n, cc_we, sess_we, static_en, restore_en, go, slow;
   reg  [1:0]  cc_idx, sess_cc;
   reg  [2:0]  sess_idx, rd_idx, scc [0:7];
   reg  [31:0] cc_src_addr, cc_dst_addr, m_src, m_dst, ca [0:4], cb [0:4];
   reg  [15:0] sess_neg_max, static_limit, frame_len, m_mtu, lim [0:7], neg [0:7];
   reg  [5:0]  sess_max_segs, m_len, segs [0:7];
   reg  [7:0]  m_type, m_code;
   reg         sess_psp_mode, packet_streaming_pseudowire [0:7];
   wire        icmp_valid, icmp_ready, icmp_last, busy;
   wire [7:0]  icmp_data;
   wire [15:0] rd_limit_r, rd_payload_r;
   wire        frame_ok_r, tx_df_flag_r, msg_applied_r, msg_dropped_r;
   integer     fail_count, total_checks, k, j, w;
   pmt_tracker #(.RESTORE_CYCLES(50)) i_pmt_tracker (.clock(clock), .rst_n(rst_n),
      .icmp_valid(icmp_valid), .icmp_ready(icmp_ready), .icmp_data(icmp_data),
      .icmp_last(icmp_last), .cc_we(cc_we), .cc_idx(cc_idx), .cc_active(1'b1),
      .cc_src_addr(cc_src_addr), .cc_dst_addr(cc_dst_addr), .sess_we(sess_we),
      .sess_idx(sess_idx), .sess_active(1'b1), .sess_cc(sess_cc),
      .sess_neg_max(sess_neg_max), .sess_psp_mode(sess_psp_mode),
      .sess_max_segs(sess_max_segs), .static_en(static_en), .static_limit(static_limit),
      .restore_en(restore_en), .rd_idx(rd_idx), .rd_limit_r(rd_limit_r),
      .rd_payload_r(rd_payload_r), .frame_len(frame_len), .frame_ok_r(frame_ok_r),
      .tx_df_flag_r(tx_df_flag_r), .msg_applied_r(msg_applied_r),
      .msg_dropped_r(msg_dropped_r));
   pmt_peer i_pmt_peer (.clock(clock), .rst_n(rst_n), .go(go), .slow(slow),
      .m_type(m_type), .m_code(m_code), .m_mtu(m_mtu), .m_src(m_src), .m_dst(m_dst),
      .m_len(m_len), .busy(busy), .icmp_valid(icmp_valid), .icmp_ready(icmp_ready),
      .icmp_data(icmp_data), .icmp_last(icmp_last));
   always #50 clock = ~clock;
   function [15:0] eff(input [2:0] s);
      eff = static_en ? (static_limit < neg[s] ? static_limit : neg[s])
                      : (lim[s] < 16'h07BE ? lim[s] : 16'h07BE);
   endfunction
   function [15:0] pay(input [2:0] s);
      reg [15:0] o;
      begin
         o = packet_streaming_pseudowire[s] ? 16'h0008 + {9'h000, segs[s], 1'b0} : 16'h0008;
         pay = eff(s) > o + 16'h0014 ? eff(s) - o - 16'h0014 : 16'h0000;
      end
   endfunction
   task chk(input [15:0] g, input [15:0] e);
      begin
         total_checks = total_checks + 1;
         if (g !== e) begin
            fail_count = fail_count + 1;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
         end
      end
   endtask
   task wrap_up;
      begin
         $display("checks=%0d errors=%0d", total_checks, fail_count);
         if (fail_count == 0 && total_checks > 0)
            $display("Finished cleanly");
         else
            $display("Finished with errors");
         $finish;
      end
   endtask
   task rdall;
      integer s;
      for (s = 0; s < 8; s = s + 1) begin
         @(posedge clock) rd_idx <= s[2:0];
         repeat (2) @(posedge clock);
         @(negedge clock);
         chk(rd_limit_r, eff(s));
         chk(rd_payload_r, pay(s));
      end
   endtask
   task wsess(input [2:0] s, input [1:0] c, input [15:0] n, input p, input [5:0] g);
      begin
         @(posedge clock);
         {sess_we, sess_idx, sess_cc, sess_neg_max, sess_psp_mode, sess_max_segs} <=
            {1'b1, s, c, n, p, g};
         @(posedge clock) sess_we <= 1'b0;
         {neg[s], lim[s], packet_streaming_pseudowire[s], segs[s], scc[s]} = {n, n, p, g, 1'b0, c};
      end
   endtask
   task msg(input [7:0] t, input [7:0] c, input [15:0] mt, input [2:0] ci, input [5:0] n);
      reg ok;
      begin
         ok = t == 8'h03 && c == 8'h04 && n >= 6'd36 && mt != 16'h0000 && ci < 3'd2;
         @(posedge clock);
         {m_type, m_code, m_mtu, m_src, m_dst, m_len, go} <= {t, c, mt, ca[ci], cb[ci], n, 1'b1};
         @(posedge clock) go <= 1'b0;
         w = 0;
         @(negedge clock);
         while (w < 300 && msg_applied_r !== 1'b1 && msg_dropped_r !== 1'b1) begin
            @(negedge clock);
            w = w + 1;
         end
         chk({15'h0000, msg_applied_r}, {15'h0000, ok});
         chk({15'h0000, msg_dropped_r}, {15'h0000, !ok});
         if (w >= 300) begin
            fail_count = fail_count + 1;
            wrap_up;
         end
         for (k = 0; k < 8; k = k + 1)
            if (ok && scc[k] == ci && mt < lim[k])
               lim[k] = mt;
      end
   endtask
   initial begin
      clock = 0;
      {rst_n, cc_we, sess_we, static_en, restore_en, go, slow, cc_idx, sess_cc} = '0;
      {sess_idx, rd_idx, cc_src_addr, cc_dst_addr, m_src, m_dst, sess_neg_max} = '0;
      {static_limit, frame_len, m_mtu, sess_max_segs, m_len, m_type, m_code} = '0;
      {sess_psp_mode, fail_count, total_checks} = '0;
      j = $urandom(84);
      for (k = 0; k < 8; k = k + 1)
         {lim[k], neg[k], packet_streaming_pseudowire[k], segs[k], scc[k]} = {39'h0, 3'h7};
      for (k = 0; k < 5; k = k + 1)
         {ca[k], cb[k]} = {$urandom, $urandom};
      repeat (10) @(posedge clock);
      rst_n <= 1'b1;
      @(posedge clock);
      @(negedge clock);
      chk({15'h0000, tx_df_flag_r}, 16'h0001);
      for (k = 0; k < 8; k = k + 1) begin
         j = k == 0 ? 0 : k == 1 ? 2000 : k == 2 ? 2001 : k == 3 ? 1 : $urandom_range(2100, 1);
         @(posedge clock) frame_len <= j[15:0];
         @(posedge clock);
         @(negedge clock);
         chk({15'h0000, frame_ok_r}, {15'h0000, j > 0 && j <= 2000});
      end
      for (k = 0; k < 2; k = k + 1) begin
         @(posedge clock);
         {cc_we, cc_idx, cc_src_addr, cc_dst_addr} <= {1'b1, k[1:0], ca[k], cb[k]};
         @(posedge clock) cc_we <= 1'b0;
      end
      wsess(0, 0, 16'h076C, 0, 0);
      wsess(1, 0, 16'h07D0, 1, 22);
      wsess(2, 1, 16'h05DC, 0, 0);
      wsess(3, 1, 16'h0708, 1, 6'h3F);
      rdall;
      msg(3, 4, 16'h0578, 0, 36);
      msg(3, 4, 16'h0640, 0, 40);
      msg(3, 4, 16'h03E8, 0, 35);
      msg(3, 4, 16'h0000, 1, 36);
      msg(3, 4, 16'h0384, 4, 36);
      rdall;
      slow <= 1'b1;
      for (j = 0; j < 20; j = j + 1)
         msg($urandom_range(3) == 0 ? 8'h0B : 8'h03, $urandom_range(3) == 0 ? 8'h03 : 8'h04,
             $urandom_range(2100, 1), $urandom_range(4, 0), $urandom_range(45, 30));
      rdall;
      @(posedge clock) {static_en, static_limit} <= {1'b1, 16'h03E8};
      rdall;
      @(posedge clock) {static_en, restore_en} <= 2'b01;
      repeat (60) @(posedge clock);
      restore_en <= 1'b0;
      for (k = 0; k < 8; k = k + 1)
         lim[k] = neg[k];
      rdall;
      wrap_up;
   end
endmodule
